// ==== cpu_state_pkg.sv ====
// Purpose: Shared constants and types for the processor state and address map block.
// Assumes: 13-bit address space, 8-bit data, one 200 MHz clock.
// Notes: Offsets are byte addresses in the processor's own address space.
`default_nettype none
package cpu_state_pkg;
   localparam int SYS_CLK_MHZ = 32'h0000_00C8;
   localparam int BLINK_US = 32'h0003_D090;
   localparam int BLINK_CYCLES_DEF = BLINK_US * SYS_CLK_MHZ;

   localparam logic [12:0] IO_GAP_LO = 13'h0007;
   localparam logic [12:0] IO_GAP_HI = 13'h0009;
   localparam logic [12:0] IO_USED_LAST = 13'h001B;
   localparam logic [12:0] IO_LAST = 13'h001F;
   localparam logic [12:0] RAM_BASE = 13'h0050;
   localparam logic [12:0] STACK_BASE = 13'h00C0;
   localparam logic [12:0] PAGE0_LAST = 13'h00FF;
   localparam logic [12:0] UROM_HI_LAST = 13'h10FF;
   localparam logic [12:0] UROM_EXT_LAST = 13'h1EFF;
   localparam logic [12:0] CHK_VEC_BASE = 13'h1FE0;
   localparam logic [12:0] WDOG_SERVICE_ADDR = 13'h1FF0;
   localparam logic [12:0] USER_VEC_BASE = 13'h1FF4;

   localparam logic [12:0] SERIAL_PERIPH_STATE_OFS = 13'h000B;
   localparam logic [12:0] SERIAL_PERIPH_SHIFT_DATA_OFS = 13'h000C;
   localparam logic [12:0] ASYNC_SERIAL_BIT_RATE_OFS = 13'h000D;
   localparam logic [12:0] ASYNC_SERIAL_CONTROL_ONE_OFS = 13'h000E;
   localparam logic [12:0] ASYNC_SERIAL_CONTROL_TWO_OFS = 13'h000F;
   localparam logic [12:0] ASYNC_SERIAL_STATE_OFS = 13'h0010;
   localparam logic [12:0] ASYNC_SERIAL_DATA_OFS = 13'h0011;
   localparam logic [12:0] TIMER_CONTROL_OFS = 13'h0012;
   localparam logic [12:0] TIMER_STATE_OFS = 13'h0013;
   localparam logic [12:0] CAPTURE_VALUE_HIGH_OFS = 13'h0014;
   localparam logic [12:0] CAPTURE_VALUE_LOW_OFS = 13'h0015;
   localparam logic [12:0] COMPARE_VALUE_HIGH_OFS = 13'h0016;
   localparam logic [12:0] COMPARE_VALUE_LOW_OFS = 13'h0017;
   localparam logic [12:0] FREE_COUNT_HIGH_OFS = 13'h0018;
   localparam logic [12:0] FREE_COUNT_LOW_OFS = 13'h0019;
   localparam logic [12:0] ALT_FREE_COUNT_HIGH_OFS = 13'h001A;
   localparam logic [12:0] ALT_FREE_COUNT_LOW_OFS = 13'h001B;
   localparam int WDOG_CLEAR_BIT = 0;

   localparam logic [6:0] STACK_PAGE = 7'h03;
   localparam logic [5:0] SP_TOP = 6'h3F;
   localparam logic [2:0] CALL_BYTES = 3'h2;
   localparam logic [2:0] INT_BYTES = 3'h5;

   localparam int CCR_H = 4;
   localparam int CCR_I = 3;
   localparam int CCR_N = 2;
   localparam int CCR_Z = 1;
   localparam int CCR_C = 0;
   localparam logic [4:0] CCR_RESET = 5'h08;

   localparam logic [3:0] PAT_BAD_IO = 4'h8;
   localparam logic [3:0] PAT_BAD_RAM = 4'h9;
   localparam logic [3:0] PAT_BAD_TIMER = 4'hA;
   localparam logic [3:0] PAT_BAD_SCI = 4'hB;
   localparam logic [3:0] PAT_BAD_ROM = 4'hC;
   localparam logic [3:0] PAT_BAD_SPI = 4'hD;
   localparam logic [3:0] PAT_BAD_DEVICE = 4'h0;
   localparam logic [3:0] PAT_ALL_OFF = 4'hF;

   typedef enum logic [3:0] {
      REG_IO, REG_IO_UNUSED, REG_USER_ROM, REG_RAM, REG_STACK, REG_UNUSED,
      REG_CHECK_ROM, REG_CHECK_VEC, REG_WATCHDOG, REG_VEC_UNUSED, REG_USER_VEC
   } region_t;

   typedef enum logic [2:0] {
      TEST_IO, TEST_RAM, TEST_TIMER, TEST_SCI, TEST_ROM, TEST_SPI, TEST_INT
   } self_test_t;

   typedef enum logic [1:0] {CHK_OFF, CHK_RUN, CHK_PASS, CHK_FAIL} check_state_t;

   typedef struct packed {
      logic valid;
      logic write;
      logic [12:0] addr;
      logic [7:0] wdata;
   } bus_req_t;

   typedef struct packed {
      logic valid;
      logic withCarry;
      logic [7:0] operand;
   } add_req_t;

   typedef struct packed {
      logic valid;
      logic updC;
      logic carry;
      logic [7:0] result;
   } alu_update_t;
endpackage
`default_nettype wire

// ==== cpu_state_and_memory_map.sv ====
// Purpose: Programmer-visible processor state, stack handling, address decode and self-check reporting.
// Assumes: All strobes come from logic on sys_clk; the two self-check entry pins come from outside.
// Notes: Instruction sequencing lives elsewhere; this block only keeps and updates the state.
`timescale 1ns/1ps
`default_nettype none

module cpu_state_and_memory_map
   import cpu_state_pkg::*;
#(
   parameter bit LARGE_ROM = 1'b0,
   parameter int BLINK_CYCLES = BLINK_CYCLES_DEF
) (
   input wire logic sys_clk,
   input wire logic rst,
   input wire bus_req_t busReq,
   output region_t regionFf,
   output logic [4:0] decodeOffsetFf,
   output logic regionValidFf,
   output logic watchdogClearFf,
   input wire logic pcLoad,
   input wire logic [12:0] pcLoadValue,
   input wire logic pcStep,
   output logic [12:0] programCounterFf,
   input wire logic accLoad,
   input wire logic [7:0] accValue,
   input wire logic idxLoad,
   input wire logic [7:0] idxValue,
   input wire add_req_t addReq,
   input wire alu_update_t aluUpd,
   input wire logic [12:0] idxBase,
   output logic [7:0] accumFf,
   output logic [7:0] indexFf,
   output logic [12:0] effAddrFf,
   input wire logic stackPushByte,
   input wire logic stackPullByte,
   input wire logic callPush,
   input wire logic intPush,
   input wire logic stackPointerReloadInstr,
   output logic [12:0] stackPointerFf,
   output logic [2:0] stackPendingFf,
   input wire logic ccrLoad,
   input wire logic [4:0] ccrValue,
   input wire logic setMask,
   input wire logic clearMask,
   output logic [4:0] conditionFlagsFf,
   input wire logic extIrqEvent,
   input wire logic periphIrqLevel,
   input wire logic intAccept,
   output logic extIrqLatchedFf,
   output logic intRequestFf,
   input wire logic irqHighVoltPin,
   input wire logic timerCapturePin,
   input wire logic testDone,
   input wire logic testOk,
   output logic selfCheckFf,
   output logic [3:0] selfTestResultPinsOutFf,
   output logic [3:0] selfTestResultPinsOeFf
);

   // Address decode; pure function so the region boundaries live in one place.
   function automatic region_t decodeAddr(input logic [12:0] a, input logic bigRom);
      region_t r;
      r = REG_UNUSED;
      if (a <= IO_LAST) begin
         r = ((a >= IO_GAP_LO && a <= IO_GAP_HI) || a > IO_USED_LAST) ? REG_IO_UNUSED : REG_IO;
      end else if (a < RAM_BASE) begin
         r = REG_USER_ROM;
      end else if (a < STACK_BASE) begin
         r = REG_RAM;
      end else if (a <= PAGE0_LAST) begin
         r = REG_STACK;
      end else if (a <= UROM_HI_LAST) begin
         r = REG_USER_ROM;
      end else if (a <= UROM_EXT_LAST) begin
         r = bigRom ? REG_USER_ROM : REG_UNUSED;
      end else if (a < CHK_VEC_BASE) begin
         r = REG_CHECK_ROM;
      end else if (a < WDOG_SERVICE_ADDR) begin
         r = REG_CHECK_VEC;
      end else if (a == WDOG_SERVICE_ADDR) begin
         r = REG_WATCHDOG;
      end else if (a < USER_VEC_BASE) begin
         r = REG_VEC_UNUSED;
      end else begin
         r = REG_USER_VEC;
      end
      return r;
   endfunction

   logic [5:0] nxtSpLow;
   logic [2:0] nxtPending;
   logic cin;
   logic [4:0] halfSum;
   logic [8:0] fullSum;
   logic [1:0] pinSync1Ff;
   logic [1:0] pinSync2Ff;
   logic [1:0] pinSync3Ff;
   logic [1:0] pinFiltFf;
   logic rstSeenFf;
   check_state_t checkStateFf;
   self_test_t testIdxFf;
   logic [31:0] blinkCntFf;
   logic [3:0] failPattern;

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         regionFf <= REG_IO;
         decodeOffsetFf <= 5'h00;
         regionValidFf <= 1'b0;
      end else begin
         regionValidFf <= busReq.valid;
         if (busReq.valid) begin
            regionFf <= decodeAddr(busReq.addr, LARGE_ROM);
            decodeOffsetFf <= busReq.addr[4:0];
         end
      end
   end

   // Servicing the watchdog needs a write of zero in its clear bit; reads are harmless.
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         watchdogClearFf <= 1'b0;
      end else begin
         watchdogClearFf <= busReq.valid && busReq.write && busReq.addr == WDOG_SERVICE_ADDR &&
                            !busReq.wdata[WDOG_CLEAR_BIT];
      end
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         programCounterFf <= 13'h0000;
      end else if (pcLoad) begin
         programCounterFf <= pcLoadValue;
      end else if (pcStep) begin
         programCounterFf <= programCounterFf + 13'h0001;
      end
   end

   assign cin = addReq.withCarry & conditionFlagsFf[CCR_C];
   assign halfSum = {1'b0, accumFf[3:0]} + {1'b0, addReq.operand[3:0]} + {4'h0, cin};
   assign fullSum = {1'b0, accumFf} + {1'b0, addReq.operand} + {8'h00, cin};

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         accumFf <= 8'h00;
      end else if (addReq.valid) begin
         accumFf <= fullSum[7:0];
      end else if (accLoad) begin
         accumFf <= accValue;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         indexFf <= 8'h00;
         effAddrFf <= 13'h0000;
      end else begin
         if (idxLoad) begin
            indexFf <= idxValue;
         end
         effAddrFf <= idxBase + {5'h00, indexFf};
      end
   end

   // Burst pushes own the pointer until done, so a stray single push cannot interleave.
   always_comb begin
      nxtSpLow = stackPointerFf[5:0];
      nxtPending = stackPendingFf;
      if (stackPendingFf != 3'h0) begin
         nxtSpLow = stackPointerFf[5:0] - 6'h01;
         nxtPending = stackPendingFf - 3'h1;
      end else if (callPush) begin
         nxtSpLow = stackPointerFf[5:0] - 6'h01;
         nxtPending = CALL_BYTES - 3'h1;
      end else if (intPush) begin
         nxtSpLow = stackPointerFf[5:0] - 6'h01;
         nxtPending = INT_BYTES - 3'h1;
      end else if (stackPushByte) begin
         nxtSpLow = stackPointerFf[5:0] - 6'h01;
      end else if (stackPullByte) begin
         nxtSpLow = stackPointerFf[5:0] + 6'h01;
      end
   end

   // Six-bit arithmetic gives the wrap from the bottom back to the top for free.
   always_ff @(posedge sys_clk) begin
      if (rst || stackPointerReloadInstr) begin
         stackPointerFf <= {STACK_PAGE, SP_TOP};
         stackPendingFf <= 3'h0;
      end else begin
         stackPointerFf <= {STACK_PAGE, nxtSpLow};
         stackPendingFf <= nxtPending;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         conditionFlagsFf <= CCR_RESET;
      end else if (ccrLoad) begin
         conditionFlagsFf <= ccrValue;
      end else begin
         if (addReq.valid) begin
            conditionFlagsFf[CCR_H] <= halfSum[4];
            conditionFlagsFf[CCR_N] <= fullSum[7];
            conditionFlagsFf[CCR_Z] <= fullSum[7:0] == 8'h00;
            conditionFlagsFf[CCR_C] <= fullSum[8];
         end else if (aluUpd.valid) begin
            conditionFlagsFf[CCR_N] <= aluUpd.result[7];
            conditionFlagsFf[CCR_Z] <= aluUpd.result == 8'h00;
            if (aluUpd.updC) begin
               conditionFlagsFf[CCR_C] <= aluUpd.carry;
            end
         end
         if (intPush || setMask) begin
            conditionFlagsFf[CCR_I] <= 1'b1;
         end else if (clearMask) begin
            conditionFlagsFf[CCR_I] <= 1'b0;
         end
      end
   end

   // A new external event wins over an acknowledge in the same cycle.
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         extIrqLatchedFf <= 1'b0;
      end else if (extIrqEvent) begin
         extIrqLatchedFf <= 1'b1;
      end else if (intAccept) begin
         extIrqLatchedFf <= 1'b0;
      end
   end

   // Peripheral requests are only sampled live, never stored.
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         intRequestFf <= 1'b0;
      end else begin
         intRequestFf <= !conditionFlagsFf[CCR_I] && (extIrqLatchedFf || periphIrqLevel);
      end
   end

   // Entry pins are asynchronous; a level counts once stages two and three agree.
   always_ff @(posedge sys_clk) begin
      pinSync1Ff <= {irqHighVoltPin, timerCapturePin};
      pinSync2Ff <= pinSync1Ff;
      pinSync3Ff <= pinSync2Ff;
      if (pinSync2Ff[0] == pinSync3Ff[0]) begin
         pinFiltFf[0] <= pinSync3Ff[0];
      end
      if (pinSync2Ff[1] == pinSync3Ff[1]) begin
         pinFiltFf[1] <= pinSync3Ff[1];
      end
   end

   // Entry straps are sampled on the first edge after reset is released.
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         rstSeenFf <= 1'b1;
         selfCheckFf <= 1'b0;
      end else begin
         rstSeenFf <= 1'b0;
         if (rstSeenFf) begin
            selfCheckFf <= pinFiltFf[1] && pinFiltFf[0];
         end
      end
   end

   always_comb begin
      case (testIdxFf)
         TEST_IO: failPattern = PAT_BAD_IO;
         TEST_RAM: failPattern = PAT_BAD_RAM;
         TEST_TIMER: failPattern = PAT_BAD_TIMER;
         TEST_SCI: failPattern = PAT_BAD_SCI;
         TEST_ROM: failPattern = PAT_BAD_ROM;
         TEST_SPI: failPattern = PAT_BAD_SPI;
         default: failPattern = PAT_BAD_DEVICE;
      endcase
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         checkStateFf <= CHK_OFF;
         testIdxFf <= TEST_IO;
      end else begin
         case (checkStateFf)
            CHK_OFF: begin
               if (rstSeenFf && pinFiltFf[1] && pinFiltFf[0]) begin
                  checkStateFf <= CHK_RUN;
               end
            end
            CHK_RUN: begin
               if (testDone && !testOk) begin
                  checkStateFf <= CHK_FAIL;
               end else if (testDone && testIdxFf == TEST_INT) begin
                  checkStateFf <= CHK_PASS;
               end else if (testDone) begin
                  testIdxFf <= self_test_t'(testIdxFf + 3'h1);
               end
            end
            CHK_PASS: checkStateFf <= CHK_PASS;
            CHK_FAIL: checkStateFf <= CHK_FAIL;
            default: checkStateFf <= CHK_OFF;
         endcase
      end
   end

   // Blink divider is kept slow enough to see on an indicator; shorten it for simulation.
   always_ff @(posedge sys_clk) begin
      if (rst || checkStateFf != CHK_PASS || blinkCntFf == 32'(BLINK_CYCLES - 1)) begin
         blinkCntFf <= 32'h0000_0000;
      end else begin
         blinkCntFf <= blinkCntFf + 32'h0000_0001;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         selfTestResultPinsOutFf <= PAT_ALL_OFF;
         selfTestResultPinsOeFf <= 4'h0;
      end else begin
         selfTestResultPinsOeFf <= {4{checkStateFf != CHK_OFF}};
         case (checkStateFf)
            CHK_FAIL: selfTestResultPinsOutFf <= failPattern;
            CHK_PASS: begin
               if (blinkCntFf == 32'(BLINK_CYCLES - 1)) begin
                  selfTestResultPinsOutFf <= ~selfTestResultPinsOutFf;
               end
            end
            default: selfTestResultPinsOutFf <= PAT_ALL_OFF;
         endcase
      end
   end

   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (rst);

   sequence noReload2;
      (!stackPointerReloadInstr)[*2];
   endsequence

   sequence noReload5;
      (!stackPointerReloadInstr)[*5];
   endsequence

   AST_SP_PAGE: assert property (stackPointerFf[12:6] == STACK_PAGE)
      else $error("Stack pointer upper bits left the stack page.");

   AST_RESET_STATE: assert property (disable iff (1'b0) rst |=>
         conditionFlagsFf[CCR_I] && stackPointerFf == {STACK_PAGE, SP_TOP})
      else $error("Reset did not set mask or stack top.");

   AST_RELOAD_TOP: assert property (stackPointerReloadInstr |=> stackPointerFf[5:0] == SP_TOP)
      else $error("Stack reload did not reach the top.");

   AST_WRAP: assert property (stackPushByte && stackPendingFf == 3'h0 && !callPush && !intPush &&
         !stackPointerReloadInstr && stackPointerFf[5:0] == 6'h00 |=> stackPointerFf[5:0] == SP_TOP)
      else $error("Stack pointer did not wrap to the top.");

   AST_CALL_TWO: assert property (callPush && stackPendingFf == 3'h0 && !stackPointerReloadInstr ##0
         noReload2 |=> stackPointerFf[5:0] == $past(stackPointerFf[5:0], 2) - 6'h02)
      else $error("Call did not push two bytes.");

   AST_INT_FIVE: assert property (intPush && !callPush && stackPendingFf == 3'h0 ##0 noReload5
         |=> stackPointerFf[5:0] == $past(stackPointerFf[5:0], 5) - 6'h05 && stackPendingFf == 3'h0)
      else $error("Interrupt entry did not push five bytes.");

   AST_HALF: assert property (addReq.valid && !ccrLoad |=>
         conditionFlagsFf[CCR_H] == ($past(accumFf[4]) ^ $past(addReq.operand[4]) ^ accumFf[4]) &&
         accumFf == $past(accumFf) + $past(addReq.operand) + {7'h00, $past(cin)})
      else $error("Half-carry or sum wrong after add.");

   AST_NZ: assert property (aluUpd.valid && !addReq.valid && !ccrLoad |=>
         conditionFlagsFf[CCR_N] == $past(aluUpd.result[7]) &&
         conditionFlagsFf[CCR_Z] == ($past(aluUpd.result) == 8'h00))
      else $error("Negative or zero flag wrong after result.");

   AST_MASK_BLOCKS: assert property (intRequestFf |-> !$past(conditionFlagsFf[CCR_I]))
      else $error("Interrupt requested while masked.");

   AST_EXT_HELD: assert property (extIrqEvent && conditionFlagsFf[CCR_I] |=> extIrqLatchedFf)
      else $error("External event lost while masked.");

   AST_WDOG: assert property (busReq.valid && busReq.write && busReq.addr == WDOG_SERVICE_ADDR &&
         !busReq.wdata[WDOG_CLEAR_BIT] |=> watchdogClearFf)
      else $error("Watchdog service write not seen.");

   AST_PC_STEP: assert property (pcStep && !pcLoad |=> programCounterFf == $past(programCounterFf) + 13'h0001)
      else $error("Program counter did not step by one.");

   AST_FAIL_STATIC: assert property (checkStateFf == CHK_FAIL ##1 checkStateFf == CHK_FAIL ##1
         checkStateFf == CHK_FAIL |->
         $stable(selfTestResultPinsOutFf) && selfTestResultPinsOeFf == 4'hF)
      else $error("Fail code on result pins is not static.");

endmodule // cpu_state_and_memory_map
`default_nettype wire

// ==== self_check_fixture.sv ====
// Purpose: Outside fixture that straps the self-check entry pins around a reset.
// Assumes: The bench sets the strap in the same step that raises reset and holds it through reset.
// Notes: Stands in for the resistor network on the two entry pins.
`timescale 1ns/1ps
`default_nettype none
module self_check_fixture (
   input wire logic enable,
   output logic highVoltPin,
   output logic capturePin
);
   // Both straps move together, so the device never sees half an entry request.
   assign highVoltPin = enable;
   assign capturePin = enable;
endmodule // self_check_fixture
`default_nettype wire

// ==== cpu_state_and_memory_map_bench.sv ====
// Purpose: Self-checking bench for processor state, stack, flags, decode and self-check pins.
// Assumes: Inputs change 1 ns after the rising edge; blink period shortened to 8 cycles.
// Notes: Expected values are worked out by hand from the map and flag behaviour.
`timescale 1ns/1ps
`default_nettype none
module cpu_state_and_memory_map_bench;
   import cpu_state_pkg::*;
   logic sys_clk = 1'b0, rst = 1'b1, strap = 1'b0, hvPin, capPin;
   bus_req_t busReq = '0;
   add_req_t addReq = '0;
   alu_update_t aluUpd = '0;
   logic pcLoad = 1'b0, pcStep = 1'b0, accLoad = 1'b0, idxLoad = 1'b0, stackPushByte = 1'b0;
   logic stackPullByte = 1'b0, callPush = 1'b0, intPush = 1'b0, stackPointerReloadInstr = 1'b0;
   logic ccrLoad = 1'b0, setMask = 1'b0, clearMask = 1'b0, extIrqEvent = 1'b0, periphIrqLevel = 1'b0;
   logic intAccept = 1'b0, testDone = 1'b0, testOk = 1'b0;
   logic [12:0] pcLoadValue = 13'h0000, idxBase = 13'h0000;
   logic [7:0] accValue = 8'h00, idxValue = 8'h00;
   logic [4:0] ccrValue = 5'h00;
   region_t regionFf, bigRegion;
   logic [4:0] decodeOffsetFf, conditionFlagsFf;
   logic regionValidFf, watchdogClearFf, extIrqLatchedFf, intRequestFf, selfCheckFf;
   logic [12:0] programCounterFf, effAddrFf, stackPointerFf;
   logic [7:0] accumFf, indexFf;
   logic [2:0] stackPendingFf;
   logic [3:0] selfTestResultPinsOutFf, selfTestResultPinsOeFf;
   int error_cnt = 0, check_count = 0;
   logic [12:0] adr [12] = '{13'h001B, 13'h0008, 13'h001C, 13'h0020, 13'h00BF, 13'h00C0, 13'h10FF,
      13'h1100, 13'h1F00, 13'h1FE0, 13'h1FF1, 13'h1FFE};
   region_t expRegion [12] = '{REG_IO, REG_IO_UNUSED, REG_IO_UNUSED, REG_USER_ROM, REG_RAM, REG_STACK,
      REG_USER_ROM, REG_UNUSED, REG_CHECK_ROM, REG_CHECK_VEC, REG_VEC_UNUSED, REG_USER_VEC};

   always #2.5 sys_clk = ~sys_clk;

   self_check_fixture u_self_check_fixture (.enable(strap), .highVoltPin(hvPin), .capturePin(capPin));

   cpu_state_and_memory_map #(.LARGE_ROM(1'b0), .BLINK_CYCLES(8)) u_cpu_state_and_memory_map (
      .sys_clk, .rst, .busReq, .regionFf, .decodeOffsetFf, .regionValidFf, .watchdogClearFf, .pcLoad,
      .pcLoadValue, .pcStep, .programCounterFf, .accLoad, .accValue, .idxLoad, .idxValue, .addReq, .aluUpd,
      .idxBase, .accumFf, .indexFf, .effAddrFf, .stackPushByte, .stackPullByte, .callPush, .intPush,
      .stackPointerReloadInstr, .stackPointerFf, .stackPendingFf, .ccrLoad, .ccrValue, .setMask, .clearMask,
      .conditionFlagsFf, .extIrqEvent, .periphIrqLevel, .intAccept, .extIrqLatchedFf, .intRequestFf,
      .irqHighVoltPin(hvPin), .timerCapturePin(capPin), .testDone, .testOk, .selfCheckFf,
      .selfTestResultPinsOutFf, .selfTestResultPinsOeFf);

   // Larger-memory variant, watched only for its decode.
   cpu_state_and_memory_map #(.LARGE_ROM(1'b1), .BLINK_CYCLES(8)) u_cpu_state_and_memory_map_big (
      .sys_clk, .rst, .busReq, .regionFf(bigRegion), .decodeOffsetFf(), .regionValidFf(), .watchdogClearFf(),
      .pcLoad, .pcLoadValue, .pcStep, .programCounterFf(), .accLoad, .accValue, .idxLoad, .idxValue, .addReq,
      .aluUpd, .idxBase, .accumFf(), .indexFf(), .effAddrFf(), .stackPushByte, .stackPullByte, .callPush,
      .intPush, .stackPointerReloadInstr, .stackPointerFf(), .stackPendingFf(), .ccrLoad, .ccrValue, .setMask,
      .clearMask, .conditionFlagsFf(), .extIrqEvent, .periphIrqLevel, .intAccept, .extIrqLatchedFf(),
      .intRequestFf(), .irqHighVoltPin(hvPin), .timerCapturePin(capPin), .testDone, .testOk, .selfCheckFf(),
      .selfTestResultPinsOutFf(), .selfTestResultPinsOeFf());

   task automatic step(input int n = 1);
      repeat (n) @(posedge sys_clk);
      #1;
   endtask

   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      check_count++;
      if (seen !== exp) begin
         error_cnt++;
         $display("ERROR at %0t: seen %0h expected %0h", $time, seen, exp);
      end
   endtask

   task automatic conclude;
      if (error_cnt == 0 && check_count > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask

   // Straps change together with reset and stay put, since the synchroniser has no reset.
   task automatic doReset(input logic s);
      strap = s;
      rst = 1'b1;
      step(6);
      rst = 1'b0;
   endtask

   initial begin
      doReset(1'b0);
      chk(stackPointerFf, 16'h00FF);
      chk(conditionFlagsFf, 16'h0008);
      pcLoadValue = 13'h1FFF;
      pcLoad = 1'b1;
      step();
      pcLoad = 1'b0;
      pcStep = 1'b1;
      step();
      pcStep = 1'b0;
      chk(programCounterFf, 16'h0000);
      for (int i = 0; i < 12; i++) begin
         busReq = '{1'b1, 1'b0, adr[i], 8'h00};
         step();
         chk({regionValidFf, regionFf}, {1'b1, expRegion[i]});
         chk(bigRegion, (adr[i] == 13'h1100) ? REG_USER_ROM : expRegion[i]);
      end
      chk(decodeOffsetFf, 16'h001E);
      busReq = '{1'b1, 1'b1, WDOG_SERVICE_ADDR, 8'h00};
      step();
      chk({regionFf, watchdogClearFf}, {REG_WATCHDOG, 1'b1});
      busReq = '{1'b1, 1'b1, WDOG_SERVICE_ADDR, 8'h01};
      step();
      busReq = '0;
      chk(watchdogClearFf, 1'b0);
      accValue = 8'h08;
      accLoad = 1'b1;
      step();
      accLoad = 1'b0;
      addReq = '{1'b1, 1'b0, 8'h08};
      step();
      chk({accumFf, 3'h0, conditionFlagsFf}, 16'h1018);
      addReq = '{1'b1, 1'b0, 8'hF0};
      step();
      chk({accumFf, 3'h0, conditionFlagsFf}, 16'h000B);
      addReq = '{1'b1, 1'b1, 8'h7F};
      step();
      chk({accumFf, 3'h0, conditionFlagsFf}, 16'h801C);
      addReq = '0;
      aluUpd = '{1'b1, 1'b1, 1'b1, 8'h00};
      step();
      aluUpd = '0;
      chk(conditionFlagsFf, 16'h001B);
      ccrValue = 5'h15;
      ccrLoad = 1'b1;
      step();
      ccrLoad = 1'b0;
      chk(conditionFlagsFf, 16'h0015);
      idxValue = 8'h10;
      idxBase = 13'h1000;
      idxLoad = 1'b1;
      step();
      idxLoad = 1'b0;
      step();
      chk(effAddrFf, 16'h1010);
      chk(indexFf, 16'h0010);
      callPush = 1'b1;
      step();
      callPush = 1'b0;
      step();
      chk({stackPendingFf, stackPointerFf}, 16'h00FD);
      intPush = 1'b1;
      step();
      intPush = 1'b0;
      step(4);
      chk({stackPendingFf, stackPointerFf}, 16'h00F8);
      chk(conditionFlagsFf, 16'h001D);
      stackPointerReloadInstr = 1'b1;
      step();
      stackPointerReloadInstr = 1'b0;
      chk(stackPointerFf, 16'h00FF);
      stackPushByte = 1'b1;
      step(64);
      stackPushByte = 1'b0;
      chk(stackPointerFf, 16'h00FF);
      stackPullByte = 1'b1;
      step();
      stackPullByte = 1'b0;
      chk(stackPointerFf, 16'h00C0);
      extIrqEvent = 1'b1;
      step();
      extIrqEvent = 1'b0;
      step(2);
      chk({extIrqLatchedFf, intRequestFf}, 2'b10);
      clearMask = 1'b1;
      step();
      clearMask = 1'b0;
      step(2);
      chk(intRequestFf, 1'b1);
      intAccept = 1'b1;
      setMask = 1'b1;
      step();
      intAccept = 1'b0;
      setMask = 1'b0;
      periphIrqLevel = 1'b1;
      step(2);
      periphIrqLevel = 1'b0;
      step();
      clearMask = 1'b1;
      step();
      clearMask = 1'b0;
      step(2);
      chk({extIrqLatchedFf, intRequestFf}, 2'b00);
      doReset(1'b1);
      step(2);
      chk({selfCheckFf, selfTestResultPinsOeFf, selfTestResultPinsOutFf}, 16'h01FF);
      testOk = 1'b1;
      repeat (7) begin
         testDone = 1'b1;
         step();
         testDone = 1'b0;
         step();
      end
      for (int i = 0; i < 20 && selfTestResultPinsOutFf !== 4'h0; i++) step();
      chk(selfTestResultPinsOutFf, 16'h0000);
      step(8);
      chk(selfTestResultPinsOutFf, 16'h000F);
      testOk = 1'b0;
      doReset(1'b1);
      step(2);
      testDone = 1'b1;
      step();
      testDone = 1'b0;
      step(20);
      chk(selfTestResultPinsOutFf, 16'h0008);
      conclude();
   end

   // The whole sequence needs well under 400 cycles; allow about five times that.
   initial begin
      #10000;
      error_cnt++;
      conclude();
   end
endmodule // cpu_state_and_memory_map_bench
`default_nettype wire
